// ==== rtl/seq_pkg.sv ====
// Constants, register map and types of the synchronous byte-port sequencer.
// Assumes one APB master and one external sync clock source.
// Operation
// - Each active sync edge while armed drives the next stored byte on output ports.
// - Every output port buffer holds up to 256 bytes of 0 to 255.
// - Byte loads write from the current write index, so loads concatenate.
// - Setting the index moves the write pointer; the next load starts there.
// - After reset every output buffer is empty and its index is zero.
// - Each load leaves the index just past the last byte written.
// - Index query on an output port returns its write pointer.
// - Data query on an output port returns every loaded byte, at most 256.
// - Reset and the reset command set every capture count to zero.
// - Index query on an input port returns the bytes captured so far.
// - Sync pulses are ignored unless the whole module is armed.
// - The module stays armed until disarmed or the transfer completes.
// - The module disarms itself when every port has finished its transfer.
// - Each active sync edge while armed captures one byte per input port still below its point count.
// - Arm state reads 1 when armed and 0 when disarmed.
// - After the transfer, input data reads back in capture order.
// - Sync pulses arriving while busy is asserted are ignored.
// - Sync edge is rising after reset and may be switched to falling.
// - Busy is active high after reset and may be made active low.
// - Clear discards all output and input data and zeroes every index.
package seq_pkg;
    localparam int DEPTH = 256;
    localparam int PW    = 9;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CMD    = 8'h04;
    localparam logic [7:0] OFF_SEL    = 8'h08;
    localparam logic [7:0] OFF_DIR    = 8'h0C;
    localparam logic [7:0] OFF_DATA   = 8'h10;
    localparam logic [7:0] OFF_RDPTR  = 8'h14;
    localparam logic [7:0] OFF_INDEX  = 8'h18;
    localparam logic [7:0] OFF_POINTS = 8'h1C;
    localparam logic [7:0] OFF_LOADED = 8'h20;
    localparam int CMD_CLEAR = 0;
    localparam int CMD_RESET = 1;
    localparam logic [PW-1:0] MAX_LOAD   = 9'h100;
    localparam logic [PW-1:0] MAX_INDEX  = 9'h0FF;
    localparam logic [PW-1:0] MAX_POINTS = 9'h100;
    // Cycles the busy line stays up after an accepted sync edge.
    localparam logic [1:0] BUSY_CYC = 2'h2;
    typedef struct packed {
        logic busy_inv;
        logic clk_inv;
        logic armed;
    } cfg_t;
    localparam cfg_t CFG_RST = '{busy_inv: 1'b0, clk_inv: 1'b0, armed: 1'b0};
endpackage : seq_pkg

// ==== rtl/sync_port_pattern_sequencer.sv ====
// Synchronous byte-port sequencer with APB register access.
// Assumes sync_clock_in and port_in come from outside core_clk's domain.
`timescale 1ns/1ps
`default_nettype none
module sync_port_pattern_sequencer #(
    parameter int NP = 12
) (
    input  wire logic            core_clk,
    input  wire logic            sys_rst,
    input  wire logic [7:0]      paddr,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [31:0]     pwdata,
    output var  logic [31:0]     prdata,
    output var  logic            pready,
    output var  logic            pslverr,
    input  wire logic            sync_clock_in,
    input  wire logic [NP*8-1:0] port_in,
    output var  logic [NP*8-1:0] port_out,
    output var  logic [NP-1:0]   port_oe_n,
    output var  logic            busy_out
);
    import seq_pkg::*;
    localparam int SW = $clog2(NP);

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_CTRL) || (a == OFF_CMD) || (a == OFF_SEL) || (a == OFF_DIR)
              || (a == OFF_DATA) || (a == OFF_RDPTR) || (a == OFF_INDEX)
              || (a == OFF_POINTS) || (a == OFF_LOADED);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers. Only the second stage feeds logic; the third is edge history.
    logic            clk_s1_q, clk_s2_q, clk_s3_q;
    logic [NP*8-1:0] in_s1_q, in_s2_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            in_s1_q  <= '0;
            in_s2_q  <= '0;
        end else begin
            clk_s1_q <= sync_clock_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            in_s1_q  <= port_in;
            in_s2_q  <= in_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State.
    cfg_t          cfg_q, cfg_d;
    logic [SW-1:0] sel_q, sel_d;
    logic [NP-1:0] dir_q, dir_d;
    logic [7:0]    rdptr_q, rdptr_d;
    logic [PW-1:0] pulse_q, pulse_d;
    logic [1:0]    busy_q, busy_d;
    logic [PW-1:0] widx_q [NP];
    logic [PW-1:0] widx_d [NP];
    logic [PW-1:0] loaded_q [NP];
    logic [PW-1:0] loaded_d [NP];
    logic [PW-1:0] pts_q [NP];
    logic [PW-1:0] pts_d [NP];
    logic [PW-1:0] cnt_q [NP];
    logic [PW-1:0] cnt_d [NP];
    logic [7:0]    out_q [NP];
    logic [7:0]    out_d [NP];
    logic [7:0]    mem_q [NP][DEPTH];
    logic [NP-1:0] mem_we;
    logic [7:0]    mem_wa [NP];
    logic [7:0]    mem_wd [NP];
    logic [31:0]   prdata_d;
    logic          err_d, act, take, done, setup, acc, wr_ok;
    logic [PW-1:0] v9;

    assign act   = cfg_q.clk_inv ? (clk_s3_q & ~clk_s2_q) : (clk_s2_q & ~clk_s3_q);
    assign take  = act & cfg_q.armed & (busy_q == 2'h0);
    assign setup = psel & ~penable;
    assign acc   = psel & penable & pready;
    assign wr_ok = acc & pwrite & ~pslverr;
    assign v9    = pwdata[PW-1:0];

    always_comb begin
        done = 1'b1;
        for (int p = 0; p < NP; p++) begin
            if (dir_q[p] ? (pulse_q < loaded_q[p]) : (cnt_q[p] < pts_q[p])) begin
                done = 1'b0;
            end
        end
    end

    // Refusals are decided in the setup cycle; state cannot move before the access.
    always_comb begin
        err_d = ~mapped(paddr);
        if (pwrite) begin
            unique case (paddr)
                OFF_SEL: err_d = pwdata[7:0] >= 8'(NP);
                OFF_DATA: err_d = cfg_q.armed || (widx_q[sel_q] >= MAX_LOAD);
                OFF_INDEX: err_d = (pwdata[31:PW] != '0) || (v9 > MAX_INDEX)
                                   || (v9 > loaded_q[sel_q]);
                OFF_POINTS: err_d = (pwdata[31:PW] != '0) || (v9 > MAX_POINTS);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state for configuration, pointers, transfer and register reads.
    always_comb begin
        cfg_d    = cfg_q;
        sel_d    = sel_q;
        dir_d    = dir_q;
        rdptr_d  = rdptr_q;
        pulse_d  = pulse_q;
        widx_d   = widx_q;
        loaded_d = loaded_q;
        pts_d    = pts_q;
        cnt_d    = cnt_q;
        out_d    = out_q;
        mem_we   = '0;
        prdata_d = prdata;
        busy_d   = (busy_q != 2'h0) ? busy_q - 2'h1 : 2'h0;
        for (int p = 0; p < NP; p++) begin
            mem_wa[p] = cnt_q[p][7:0];
            mem_wd[p] = in_s2_q[p*8 +: 8];
        end
        // Drive out, capture, one byte per port per edge.
        if (take) begin
            busy_d  = BUSY_CYC;
            pulse_d = (pulse_q < MAX_LOAD) ? pulse_q + 9'h001 : pulse_q;
            for (int p = 0; p < NP; p++) begin
                if (dir_q[p] && pulse_q < loaded_q[p]) begin
                    out_d[p] = mem_q[p][pulse_q[7:0]];
                end else if (!dir_q[p] && cnt_q[p] < pts_q[p]) begin
                    mem_we[p] = 1'b1;
                    cnt_d[p]  = cnt_q[p] + 9'h001;
                end
            end
        end else if (cfg_q.armed && busy_q == 2'h0 && done) begin
            // Self disarm once every port is finished.
            cfg_d.armed = 1'b0;
        end
        if (setup) begin
            unique case (paddr)
                OFF_CTRL:   prdata_d = {29'h0, cfg_q.busy_inv, cfg_q.clk_inv, cfg_q.armed};
                OFF_SEL:    prdata_d = 32'(sel_q);
                OFF_DIR:    prdata_d = 32'(dir_q);
                // Output bytes, input bytes, read at the read pointer.
                OFF_DATA:   prdata_d = {24'h0, mem_q[sel_q][rdptr_q]};
                OFF_RDPTR:  prdata_d = {24'h0, rdptr_q};
                OFF_INDEX:  prdata_d = 32'(dir_q[sel_q] ? widx_q[sel_q] : cnt_q[sel_q]);
                OFF_POINTS: prdata_d = 32'(pts_q[sel_q]);
                OFF_LOADED: prdata_d = 32'(loaded_q[sel_q]);
                default:    prdata_d = 32'h0000_0000;
            endcase
        end
        if (acc && !pwrite && !pslverr && paddr == OFF_DATA) begin
            rdptr_d = rdptr_q + 8'h01;
        end
        if (wr_ok) begin
            unique case (paddr)
                OFF_CTRL: begin
                    // Only software or completion clears the arm.
                    if (pwdata[0] && !cfg_q.armed) begin
                        pulse_d = '0;
                    end
                    cfg_d = cfg_t'(pwdata[2:0]);
                end
                OFF_CMD: begin
                    if (pwdata[CMD_CLEAR] || pwdata[CMD_RESET]) begin
                        for (int p = 0; p < NP; p++) begin
                            widx_d[p]   = '0;
                            loaded_d[p] = '0;
                            cnt_d[p]    = '0;
                        end
                        pulse_d = '0;
                        rdptr_d = '0;
                    end
                    // Reset command zeroes counts and defaults.
                    if (pwdata[CMD_RESET]) begin
                        for (int p = 0; p < NP; p++) begin
                            pts_d[p] = '0;
                        end
                        cfg_d = CFG_RST;
                        dir_d = '0;
                    end
                end
                OFF_SEL:   sel_d = pwdata[SW-1:0];
                OFF_DIR:   dir_d = pwdata[NP-1:0];
                OFF_RDPTR: rdptr_d = pwdata[7:0];
                OFF_DATA: begin
                    // Append at index. Advance index past it.
                    mem_we[sel_q] = 1'b1;
                    mem_wa[sel_q] = widx_q[sel_q][7:0];
                    mem_wd[sel_q] = pwdata[7:0];
                    widx_d[sel_q] = widx_q[sel_q] + 9'h001;
                    if (widx_q[sel_q] + 9'h001 > loaded_q[sel_q]) begin
                        loaded_d[sel_q] = widx_q[sel_q] + 9'h001;
                    end
                end
                OFF_INDEX:  widx_d[sel_q] = v9;
                OFF_POINTS: pts_d[sel_q] = v9;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers. Buffers empty, indices zero from reset.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q     <= CFG_RST;
            sel_q     <= '0;
            dir_q     <= '0;
            rdptr_q   <= '0;
            pulse_q   <= '0;
            busy_q    <= '0;
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            busy_out  <= 1'b0;
            port_oe_n <= '1;
            for (int p = 0; p < NP; p++) begin
                widx_q[p]   <= '0;
                loaded_q[p] <= '0;
                pts_q[p]    <= '0;
                cnt_q[p]    <= '0;
                out_q[p]    <= '0;
            end
        end else begin
            cfg_q     <= cfg_d;
            sel_q     <= sel_d;
            dir_q     <= dir_d;
            rdptr_q   <= rdptr_d;
            pulse_q   <= pulse_d;
            busy_q    <= busy_d;
            prdata    <= prdata_d;
            pready    <= setup;
            pslverr   <= setup & err_d;
            // Polarity applied before the pin register.
            busy_out  <= (busy_d != 2'h0) ^ cfg_d.busy_inv;
            port_oe_n <= ~dir_d;
            widx_q    <= widx_d;
            loaded_q  <= loaded_d;
            pts_q     <= pts_d;
            cnt_q     <= cnt_d;
            out_q     <= out_d;
        end
    end

    // Byte store, 256 entries per port; left unreset, counts mark validity.
    always_ff @(posedge core_clk) begin
        for (int p = 0; p < NP; p++) begin
            if (mem_we[p]) begin
                mem_q[p][mem_wa[p]] <= mem_wd[p];
            end
        end
    end

    for (genvar g = 0; g < NP; g++) begin : g_out
        assign port_out[g*8 +: 8] = out_q[g];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_busy_window;
        (busy_q != 2'h0) [*2] ##1 (busy_q == 2'h0);
    endsequence
    property p_busy_len;
        take |=> s_busy_window;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy window length wrong");
    property p_busy_ignore;
        (busy_q != 2'h0) && act && !wr_ok |=> $stable(pulse_q);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("pulse taken while busy");
    property p_unarmed;
        !cfg_q.armed && !wr_ok |=> $stable(pulse_q) && (busy_q != BUSY_CYC);
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("pulse taken while disarmed");
    property p_advance;
        take && pulse_q < MAX_LOAD |=> pulse_q == $past(pulse_q) + 9'h001;
    endproperty
    a_advance: assert property (p_advance) else $error("pulse count did not advance");
    property p_busy_pin;
        busy_out == ((busy_q != 2'h0) ^ cfg_q.busy_inv);
    endproperty
    a_busy_pin: assert property (p_busy_pin) else $error("busy pin polarity wrong");
    property p_self_disarm;
        cfg_q.armed && busy_q == 2'h0 && done && !act && !wr_ok |=> !cfg_q.armed;
    endproperty
    a_self_disarm: assert property (p_self_disarm) else $error("no self disarm");
    property p_load_step;
        wr_ok && paddr == OFF_DATA |=> widx_q[sel_q] == $past(widx_q[sel_q]) + 9'h001;
    endproperty
    a_load_step: assert property (p_load_step) else $error("index not advanced");
    property p_clear;
        wr_ok && paddr == OFF_CMD && pwdata[CMD_CLEAR] |=> widx_q[sel_q] == '0
            && loaded_q[sel_q] == '0 && cnt_q[sel_q] == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left data");
    property p_refuse;
        acc && pwrite && pslverr |=> $stable(widx_q[sel_q]) && $stable(pts_q[sel_q]);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused write changed state");
endmodule : sync_port_pattern_sequencer
`default_nettype wire

// ==== test/sync_source.sv ====
// Behavioural model of the external equipment on the sync link.
// Assumes two ports: port 1 is captured by the sequencer, port 0 is driven by it.
`timescale 1ns/1ps
`default_nettype none
module sync_source (
    output var  logic        sync_clock_in,
    output var  logic [15:0] port_in,
    input  wire logic        busy_out
);
    logic busy_seen;
    logic busy_idle;

    ////////////////////////////////////////////////////////////////////////////
    // The link starts low, and the port data starts neutral.
    initial begin
        sync_clock_in = 1'b0;
        port_in       = 16'h0;
        busy_seen     = 1'b0;
        busy_idle     = 1'b0;
    end

    // One 125 ns frame: data set up, active edge, busy watched for 60 ns.
    // With twice set, a second active edge follows 10 ns later, inside the busy window.
    task automatic pulse(input logic [7:0] b, input logic fall, input logic twice);
        port_in       = {b, ~b};
        sync_clock_in = fall;
        #62.5;
        busy_idle     = busy_out;
        busy_seen     = 1'b0;
        sync_clock_in = ~fall;
        for (int i = 0; i < 12; i++) begin
            #5;
            if (busy_out !== busy_idle) begin
                busy_seen = 1'b1;
            end
            if (twice && i < 2) begin
                sync_clock_in = (i == 0) ? fall : ~fall;
            end
        end
        #2.5;
        sync_clock_in = fall;
        // Data past its hold time is inverted, so a late sample cannot match.
        port_in       = {~b, b};
    endtask : pulse
endmodule : sync_source
`default_nettype wire

// ==== test/sync_port_pattern_sequencer_test.sv ====
// Self-checking bench for the byte-port sequencer with two ports.
// Assumes the sync source model owns the link pins and port inputs.
`timescale 1ns/1ps
`default_nettype none
module sync_port_pattern_sequencer_test;
    import seq_pkg::*;
    localparam logic [7:0] LOAD [9] = '{8'h0A, 8'h14, 8'h1E, 8'h28, 8'h32, 8'h3C, 8'h46,
                                        8'h50, 8'h5A};
    localparam logic [7:0] OUT_EXP [9] = '{8'h0A, 8'h14, 8'h1E, 8'h4D, 8'h4E, 8'h3C, 8'h46,
                                           8'h50, 8'h5A};
    logic        core_clk = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [7:0]  paddr    = 8'h0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sync_clock_in;
    logic        busy_out;
    logic [15:0] port_in;
    logic [15:0] port_out;
    logic [1:0]  port_oe_n;
    logic [31:0] rdat;
    logic        rerr;
    int          n_fail      = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Design and the far-side equipment.
    sync_port_pattern_sequencer #(.NP(2)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_clock_in(sync_clock_in),
        .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n), .busy_out(busy_out)
    );
    sync_source u_src (.sync_clock_in(sync_clock_in), .port_in(port_in), .busy_out(busy_out));

    // Clock, and a ceiling that cuts a hang short well above the expected run.
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, APB transfer and register shorthands.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Request held until pready is sampled high at a rising edge; answer taken there.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check(32'(rerr), 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdat, e);
        check(32'(rerr), 32'h0);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and an unmapped address.
    task automatic t_reset;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_POINTS, 32'h0);
        rd(OFF_INDEX, 32'h0);
        rd(OFF_LOADED, 32'h0);
        check(32'(port_out), 32'h0);
        check(32'(port_oe_n), 32'h3);
        check(32'(busy_out), 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check(32'(rerr), 32'h1);
        $display("test reset done");
    endtask : t_reset

    // Appending loads, index move, overwrite and read-back of port 0.
    task automatic t_load;
        wr(OFF_SEL, 32'h0);
        wr(OFF_DIR, 32'h1);
        for (int i = 0; i < 9; i++) begin
            wr(OFF_DATA, 32'(LOAD[i]));
        end
        rd(OFF_INDEX, 32'h9);
        check(32'(port_oe_n), 32'h2);
        apb(1'b1, OFF_INDEX, 32'hA);
        check(32'(rerr), 32'h1);
        wr(OFF_INDEX, 32'h3);
        wr(OFF_DATA, 32'h4D);
        wr(OFF_DATA, 32'h4E);
        rd(OFF_INDEX, 32'h5);
        rd(OFF_LOADED, 32'h9);
        wr(OFF_RDPTR, 32'h0);
        for (int i = 0; i < 9; i++) begin
            rd(OFF_DATA, 32'(OUT_EXP[i]));
        end
        $display("test load done");
    endtask : t_load

    // Arm, disarm, ignored pulse, then a full run with self-disarm.
    task automatic t_run;
        wr(OFF_SEL, 32'h1);
        wr(OFF_POINTS, 32'h3);
        apb(1'b1, OFF_POINTS, 32'h101);
        check(32'(rerr), 32'h1);
        rd(OFF_POINTS, 32'h3);
        wr(OFF_CTRL, 32'h1);
        rd(OFF_CTRL, 32'h1);
        apb(1'b1, OFF_DATA, 32'h77);
        check(32'(rerr), 32'h1);
        wr(OFF_CTRL, 32'h0);
        rd(OFF_CTRL, 32'h0);
        rd(OFF_LOADED, 32'h0);
        u_src.pulse(8'hEE, 1'b0, 1'b0);
        check(32'(u_src.busy_seen), 32'h0);
        check(32'(port_out[7:0]), 32'h0);
        rd(OFF_INDEX, 32'h0);
        wr(OFF_CTRL, 32'h1);
        // The first frame carries a second edge while busy; it must not advance anything.
        for (int k = 0; k < 9; k++) begin
            u_src.pulse(8'(8'hC0 + k), 1'b0, k == 0);
            check(32'(port_out[7:0]), 32'(OUT_EXP[k]));
            check(32'(u_src.busy_seen), 32'h1);
            if (k < 8) begin
                rd(OFF_CTRL, 32'h1);
            end
        end
        rd(OFF_CTRL, 32'h0);
        rd(OFF_INDEX, 32'h3);
        wr(OFF_RDPTR, 32'h0);
        for (int k = 0; k < 3; k++) begin
            rd(OFF_DATA, 32'(8'hC0 + k));
        end
        $display("test run done");
    endtask : t_run

    // Clear, inverted busy, falling edge and the reset command.
    task automatic t_modes;
        wr(OFF_CMD, 32'h1);
        rd(OFF_INDEX, 32'h0);
        wr(OFF_SEL, 32'h0);
        rd(OFF_INDEX, 32'h0);
        rd(OFF_LOADED, 32'h0);
        wr(OFF_DATA, 32'hA5);
        wr(OFF_DATA, 32'h5A);
        wr(OFF_SEL, 32'h1);
        wr(OFF_POINTS, 32'h0);
        wr(OFF_CTRL, 32'h6);
        @(negedge core_clk);
        check(32'(busy_out), 32'h1);
        wr(OFF_CTRL, 32'h7);
        u_src.pulse(8'h11, 1'b1, 1'b0);
        check(32'(port_out[7:0]), 32'hA5);
        check(32'(u_src.busy_seen), 32'h1);
        rd(OFF_CTRL, 32'h7);
        u_src.pulse(8'h22, 1'b1, 1'b0);
        check(32'(port_out[7:0]), 32'h5A);
        rd(OFF_CTRL, 32'h6);
        wr(OFF_POINTS, 32'h100);
        rd(OFF_POINTS, 32'h100);
        wr(OFF_CMD, 32'h2);
        rd(OFF_POINTS, 32'h0);
        rd(OFF_CTRL, 32'h0);
        $display("test modes done");
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and the end of the run.
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Reset for two cycles, then the scenarios in order.
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_load();
        t_run();
        t_modes();
        finish_test();
    end
endmodule : sync_port_pattern_sequencer_test
`default_nettype wire
